// [tb/acc_analog_model.sv]
// Behavioural analog comparator core facing the control block
`timescale 1ns/1ps
module acc_analog_model #(
  parameter int BANDGAP_MV = 1200 // Plain default level
) (
  input  wire logic       i_power_off,
  input  wire logic       i_bandgap_sel,
  input  wire logic       i_use_mux,
  input  wire logic [2:0] i_mux_sel,
  input  var  int         i_pos_mv,
  input  var  int         i_neg_mv,
  input  var  int         i_conv_mv [8],
  output logic            o_result
);
  int pos_mv;
  int neg_mv;
  // Unpowered core reads low, so a stale high never leaks through
  always_comb begin
    pos_mv = i_bandgap_sel ? BANDGAP_MV : i_pos_mv;
    neg_mv = i_use_mux ? i_conv_mv[i_mux_sel] : i_neg_mv;
    o_result = !i_power_off && (pos_mv > neg_mv);
  end
endmodule // acc_analog_model

// [tb/acc_comparator_control_tb_top.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module acc_comparator_control_tb_top;
  import acc_pkg::*;
  logic        i_clock, i_rst_b, psel, pen, pwr, gie, ack, cmp, rdy, slv;
  logic        slverr, off, bg, use_mux, cap, cmp_irq, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rq;
  logic [2:0]  sel;
  int          errors, comparisons, pos_mv, neg_mv;
  int          cycles = 0;
  int          conv_mv [8];

  acc_comparator_control uut (.i_clock, .i_rst_b, .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
    .o_prdata(rdata), .o_pready(rdy), .o_pslverr(slv), .i_global_irq_en(gie),
    .i_vector_ack(ack), .i_cmp_result(cmp), .o_cmp_power_off(off),
    .o_pos_bandgap_sel(bg), .o_neg_use_mux(use_mux), .o_neg_mux_sel(sel),
    .o_capture_trigger(cap), .o_cmp_irq(cmp_irq), .o_irq(irq));
  acc_analog_model core (.i_power_off(off), .i_bandgap_sel(bg),
    .i_use_mux(use_mux), .i_mux_sel(sel), .i_pos_mv(pos_mv),
    .i_neg_mv(neg_mv), .i_conv_mv(conv_mv), .o_result(cmp));

  // Clock at 200 MHz
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  // Hang guard; the run needs well under two thousand cycles
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  // Comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One APB transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    do @(posedge i_clock); while (rdy !== 1'b1);
    rq = rdata;
    slverr = slv;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rq, e);
  endtask
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence; reserved mode keeps the flag quiet while routing
  initial begin
    {i_rst_b, psel, pen, pwr, gie, ack} = 6'h0;
    addr = 12'h0;
    wdata = 32'h0;
    {pos_mv, neg_mv} = {32'd1000, 32'd2000};
    conv_mv = '{default: 3000};
    {errors, comparisons} = {32'd0, 32'd0};
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(ADDR_SPECIAL_IO, 32'h0);
    rd(ADDR_CMP_CTRL, 32'h0);
    rd(12'h018, 32'h0);
    chk_pin(slverr, 1'b1);
    xfer(1'b1, ADDR_CMP_CTRL, 32'h01);
    xfer(1'b1, ADDR_SPECIAL_IO, 32'h08);
    for (int n = 0; n < 8; n++) begin
      conv_mv[n] <= 500;
      xfer(1'b1, ADDR_CORE_CTRL, n);
      repeat (4) @(posedge i_clock);
      chk(32'(sel), n);
      rd(ADDR_CMP_CTRL, 32'h21);
      conv_mv[n] <= 3000;
    end
    conv_mv[7] <= 500;
    xfer(1'b1, ADDR_CORE_CTRL, 32'h0f);
    chk_pin(use_mux, 1'b0);
    repeat (3) @(posedge i_clock);
    rd(ADDR_CMP_CTRL, 32'h01);
    xfer(1'b1, ADDR_CORE_CTRL, 32'h07);
    xfer(1'b1, ADDR_SPECIAL_IO, 32'h0);
    chk_pin(use_mux, 1'b0);
    neg_mv <= 1100;
    xfer(1'b1, ADDR_CMP_CTRL, 32'h41);
    repeat (3) @(posedge i_clock);
    chk_pin(bg, 1'b1);
    rd(ADDR_CMP_CTRL, 32'h61);
    xfer(1'b1, ADDR_CMP_CTRL, 32'h81);
    chk_pin(off, 1'b1);
    xfer(1'b1, ADDR_CMP_CTRL, 32'h01);
    // Every edge mode, a rise then a fall; enable stays off meanwhile
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, ADDR_CMP_CTRL, 32'h10 | m);
      pos_mv <= 3000;
      repeat (6) @(posedge i_clock);
      xfer(1'b1, ADDR_CMP_CTRL, m);
      rd(ADDR_CMP_CTRL, 32'h20 | m | ((m == 0 || m == 3) << 4));
      xfer(1'b1, ADDR_CMP_CTRL, 32'h10 | m);
      pos_mv <= 1000;
      repeat (6) @(posedge i_clock);
      rd(ADDR_CMP_CTRL, m | ((m == 0 || m == 2) << 4));
    end
    rd(ADDR_IRQ_STATUS, 32'h1);
    xfer(1'b1, ADDR_IRQ_CLEAR, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h0);
    xfer(1'b1, ADDR_IRQ_ENABLE, 32'h1);
    rd(ADDR_IRQ_ENABLE, 32'h1);
    xfer(1'b1, ADDR_CMP_CTRL, 32'h10);
    xfer(1'b1, ADDR_CMP_CTRL, 32'h08);
    gie <= 1'b1;
    pos_mv <= 3000;
    repeat (8) @(posedge i_clock);
    chk_pin(cmp_irq, 1'b1);
    chk_pin(irq, 1'b1);
    gie <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk_pin(cmp_irq, 1'b0);
    gie <= 1'b1;
    repeat (2) @(posedge i_clock);
    chk_pin(cmp_irq, 1'b1);
    ack <= 1'b1;
    @(posedge i_clock);
    ack <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk_pin(cmp_irq, 1'b0);
    rd(ADDR_CMP_CTRL, 32'h28);
    xfer(1'b1, ADDR_IRQ_ENABLE, 32'h0);
    chk_pin(irq, 1'b0);
    rd(ADDR_IRQ_STATUS, 32'h1);
    xfer(1'b1, ADDR_CMP_CTRL, 32'h04);
    chk_pin(cap, 1'b1);
    xfer(1'b1, ADDR_CMP_CTRL, 32'h00);
    chk_pin(cap, 1'b0);
    report_and_stop();
  end
endmodule // acc_comparator_control_tb_top

// [tb/acc_props.sv]
// Port checker for the comparator control block, bound to its top
`timescale 1ns/1ps
module acc_props (
  input wire logic                      i_clock,
  input wire logic                      i_rst_b,
  input wire logic                      i_psel,
  input wire logic                      i_penable,
  input wire logic                      i_pwrite,
  input wire logic                      i_global_irq_en,
  input wire logic                      i_vector_ack,
  input wire logic                      i_cmp_result,
  input wire logic                      o_pready,
  input wire logic                      o_cmp_power_off,
  input wire logic                      o_pos_bandgap_sel,
  input wire logic                      o_neg_use_mux,
  input wire logic [acc_pkg::SEL_W-1:0] o_neg_mux_sel,
  input wire logic                      o_capture_trigger,
  input wire logic                      o_cmp_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_ready_wait: assert property (i_psel && i_penable && !o_pready
    |=> o_pready) else $error("late answer");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  a_irq_gated: assert property (!i_global_irq_en |=> !o_cmp_irq)
    else $error("request without global enable");
  a_ack_clears: assert property (i_vector_ack |-> ##[1:2] !o_cmp_irq)
    else $error("request kept after vector");
  a_sel_idle: assert property (!o_neg_use_mux |-> o_neg_mux_sel == 3'h0)
    else $error("select set on dedicated pin");
  a_cap_sync: assert property (o_capture_trigger
    |-> $past(i_cmp_result, 2) || $past(i_cmp_result, 3))
    else $error("capture not synced");
  a_power_write: assert property ($changed(o_cmp_power_off)
    |-> $past(i_psel, 2) && $past(i_pwrite, 2)) else $error("power moved");
  a_gap_write: assert property ($changed(o_pos_bandgap_sel)
    |-> $past(i_psel, 2) && $past(i_pwrite, 2)) else $error("bandgap moved");
endmodule // acc_props
bind acc_comparator_control acc_props u_props (.i_clock, .i_rst_b, .i_psel,
  .i_penable, .i_pwrite, .i_global_irq_en, .i_vector_ack, .i_cmp_result,
  .o_pready, .o_cmp_power_off, .o_pos_bandgap_sel, .o_neg_use_mux,
  .o_neg_mux_sel, .o_capture_trigger, .o_cmp_irq);

// [verilog/acc_comparator_control.sv]
// Comparator control logic: input routing, sync, edge interrupt, APB regs
// Summary of operation
// - With the mux enable set and converter off, pin N of the select drives the negative input.
// - Otherwise the dedicated negative pin drives the negative input.
// - The disable bit powers the comparator off when one and on when zero.
// - The bandgap bit swaps the positive input for the bandgap reference.
// - The output status bit is the comparator result after a sync delay.
// - The flag is set when a synced output edge matches the selected mode.
// - The flag clears when the processor takes the comparator vector.
// - Writing one to the flag clears it, writing zero leaves it.
// - The request is high only with flag, enable and global enable all set.
// - The capture bit routes the output to the timer capture front end.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - The analog core outputs one when positive exceeds negative.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module acc_comparator_control
  import acc_pkg::*;
#(
  parameter int NUM_INPUTS = 8
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_b,
  // APB slave
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [11:0]              i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic      [31:0]              o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // Processor side
  input  wire logic                     i_global_irq_en,
  input  wire logic                     i_vector_ack,
  // Analog core
  input  wire logic                     i_cmp_result,
  output logic                          o_cmp_power_off,
  output logic                          o_pos_bandgap_sel,
  output logic                          o_neg_use_mux,
  output logic [acc_pkg::SEL_W-1:0]     o_neg_mux_sel,
  // Timer capture and interrupts
  output logic                          o_capture_trigger,
  output logic                          o_cmp_irq,
  output logic                          o_irq
);

  // The reset synchroniser stays outside the state record: it runs on the
  // raw reset while everything else runs on its released copy, and a record
  // written from two processes would have two drivers
  typedef struct packed {
    logic [1:0]       cmp_sync;
    logic             cmp_prev;
    logic [7:0]       special_io_reg;
    logic [7:0]       ctrl_reg;
    logic [3:0]       core_reg;
    logic [EVT_W-1:0] status_reg;
    logic [EVT_W-1:0] enable_reg;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             power_off;
    logic             bandgap;
    logic             use_mux;
    logic [SEL_W-1:0] mux_sel;
    logic             capture;
    logic             cmp_irq;
    logic             irq;
  } acc_state_t;

  acc_state_t state_reg;
  acc_state_t state_next;
  logic [1:0] rst_sync_reg;
  logic       rst_b;

  // Reset is released through two flops; assert stays asynchronous.
  // Releasing on the clock keeps every flop leaving reset in one cycle,
  // so no register sees half of the block awake
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];

  // Decodes whether a bus write hits a given address
  function automatic logic wr_hit(input logic [11:0] addr);
    return i_psel && i_penable && i_pwrite && !state_reg.pready &&
           (i_paddr == addr);
  endfunction

  // Edge match per mode; reserved mode never fires
  function automatic logic edge_match(input logic [1:0] mode,
                                      input logic       cur,
                                      input logic       prev);
    logic hit;
    hit = 1'b0;
    case (mode)
      MODE_TOGGLE:  hit = cur ^ prev;
      MODE_RSVD:    hit = 1'b0;
      MODE_FALLING: hit = prev & ~cur;
      MODE_RISING:  hit = cur & ~prev;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Sticky bit update: cleared by its clear source, but a new event in the
  // same cycle wins so an edge that lands on the clear is never lost
  function automatic logic flag_update(input logic cur,
                                       input logic clr,
                                       input logic set);
    logic nxt;
    nxt = cur;
    if (clr) begin
      nxt = 1'b0;
    end
    if (set) begin
      nxt = 1'b1;
    end
    return nxt;
  endfunction

  // Negative input routing: the converter pins only take over while the
  // converter itself is off, since it owns the same multiplexer.
  // A select beyond the fitted pins falls back to the dedicated pin
  function automatic logic route_to_mux(input logic [7:0] sfio,
                                        input logic [3:0] core);
    logic on;
    on = sfio[BIT_NEG_MUX_EN] && !core[BIT_CONV_EN];
    if (32'(core[SEL_LSB +: SEL_W]) >= NUM_INPUTS) begin
      on = 1'b0;
    end
    return on;
  endfunction

  // True for every address that holds a register; anything else is refused
  function automatic logic addr_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      ADDR_SPECIAL_IO: hit = 1'b1;
      ADDR_CMP_CTRL:   hit = 1'b1;
      ADDR_IRQ_STATUS: hit = 1'b1;
      ADDR_IRQ_CLEAR:  hit = 1'b1;
      ADDR_IRQ_ENABLE: hit = 1'b1;
      ADDR_CORE_CTRL:  hit = 1'b1;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Read word for an address; registers are narrower than the bus, so the
  // upper bits are zero rather than left floating. The clear register is
  // write-only and reads zero so software never mistakes it for status
  function automatic logic [31:0] read_word(input logic [11:0] addr,
                                            input logic [7:0]  ctrl_now);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (addr)
      ADDR_SPECIAL_IO: word = 32'(state_reg.special_io_reg);
      ADDR_CMP_CTRL:   word = 32'(ctrl_now);
      ADDR_IRQ_STATUS: word = 32'(state_reg.status_reg);
      ADDR_IRQ_ENABLE: word = 32'(state_reg.enable_reg);
      ADDR_CORE_CTRL:  word = 32'(state_reg.core_reg);
      default:         word = 32'h0000_0000;
    endcase
    return word;
  endfunction

  // Next state of everything
  always_comb begin
    logic       evt;
    logic       flag;
    logic       clr;
    logic       mux_on;
    logic [7:0] ctrl_rd;
    evt     = 1'b0;
    flag    = 1'b0;
    clr     = 1'b0;
    mux_on  = 1'b0;
    ctrl_rd = 8'h00;
    state_next = state_reg;

    // Two-flop sync of the analog result; second stage is the status bit
    state_next.cmp_sync = {state_reg.cmp_sync[0], i_cmp_result};
    state_next.cmp_prev = state_reg.cmp_sync[1];

    // Edge compare on synced samples, gated by the mode bits
    evt = edge_match(state_reg.ctrl_reg[BIT_MODE_HI:BIT_MODE_LO],
                     state_reg.cmp_sync[1], state_reg.cmp_prev);

    // Flag clear by vector or by a one written; a new event wins
    clr = i_vector_ack;
    if (wr_hit(ADDR_CMP_CTRL) && i_pwdata[BIT_IRQ_FLAG]) begin
      clr = 1'b1;
    end
    flag = flag_update(state_reg.ctrl_reg[BIT_IRQ_FLAG], clr, evt);

    // Control register writes; output and flag bits are not stored
    if (wr_hit(ADDR_CMP_CTRL)) begin
      state_next.ctrl_reg = i_pwdata[7:0];
    end
    state_next.ctrl_reg[BIT_OUT_SYNC] = 1'b0;
    state_next.ctrl_reg[BIT_IRQ_FLAG] = flag;

    // Special function register; bit 4 reads as zero
    if (wr_hit(ADDR_SPECIAL_IO)) begin
      state_next.special_io_reg = i_pwdata[7:0];
      state_next.special_io_reg[BIT_SFIO_RO] = 1'b0;
    end
    if (wr_hit(ADDR_CORE_CTRL)) begin
      state_next.core_reg = i_pwdata[3:0];
    end

    // Block status register: sticky event, W1C clear, set wins
    // The block status bit follows the same set-wins rule as the flag
    state_next.status_reg[EVT_CMP] =
      flag_update(state_reg.status_reg[EVT_CMP],
                  wr_hit(ADDR_IRQ_CLEAR) && i_pwdata[EVT_CMP], evt);
    if (wr_hit(ADDR_IRQ_ENABLE)) begin
      state_next.enable_reg = i_pwdata[EVT_W-1:0];
    end

    // Negative input routing from next register values
    // Next values are used so the routing pins move with the write itself
    mux_on = route_to_mux(state_next.special_io_reg,
                          state_next.core_reg);
    state_next.use_mux = mux_on;
    state_next.mux_sel = mux_on ?
      state_next.core_reg[SEL_LSB +: SEL_W] : '0;
    state_next.power_off = state_next.ctrl_reg[BIT_DISABLE];
    state_next.bandgap   = state_next.ctrl_reg[BIT_BANDGAP];
    state_next.capture   = state_next.ctrl_reg[BIT_CAPTURE] &&
                           state_next.cmp_sync[1];

    // Processor request and block interrupt output
    state_next.cmp_irq = flag && state_next.ctrl_reg[BIT_IRQ_EN] &&
                         i_global_irq_en;
    state_next.irq = |(state_next.status_reg & state_next.enable_reg);

    // APB answer: one wait state, unmapped addresses give an error
    ctrl_rd = state_reg.ctrl_reg;
    ctrl_rd[BIT_OUT_SYNC] = state_reg.cmp_sync[1];
    state_next.pready  = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.prdata  = 32'h0000_0000;
    // The pready term stops a held access from being taken a second time
    if (i_psel && i_penable && !state_reg.pready) begin
      state_next.pready  = 1'b1;
      state_next.pslverr = !addr_mapped(i_paddr);
      if (!i_pwrite) begin
        state_next.prdata = read_word(i_paddr, ctrl_rd);
      end
    end
  end

  // All state but the reset synchroniser, registered on the clean reset
  always_ff @(posedge i_clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg.cmp_sync       <= 2'h0;
      state_reg.cmp_prev       <= 1'b0;
      state_reg.special_io_reg <= RST_SPECIAL_IO;
      state_reg.ctrl_reg       <= RST_CMP_CTRL;
      state_reg.core_reg       <= RST_CORE_CTRL;
      state_reg.status_reg     <= '0;
      state_reg.enable_reg     <= '0;
      state_reg.prdata         <= 32'h0000_0000;
      state_reg.pready         <= 1'b0;
      state_reg.pslverr        <= 1'b0;
      state_reg.power_off      <= 1'b0;
      state_reg.bandgap        <= 1'b0;
      state_reg.use_mux        <= 1'b0;
      state_reg.mux_sel        <= '0;
      state_reg.capture        <= 1'b0;
      state_reg.cmp_irq        <= 1'b0;
      state_reg.irq            <= 1'b0;
    end else begin
      state_reg.cmp_sync       <= state_next.cmp_sync;
      state_reg.cmp_prev       <= state_next.cmp_prev;
      state_reg.special_io_reg <= state_next.special_io_reg;
      state_reg.ctrl_reg       <= state_next.ctrl_reg;
      state_reg.core_reg       <= state_next.core_reg;
      state_reg.status_reg     <= state_next.status_reg;
      state_reg.enable_reg     <= state_next.enable_reg;
      state_reg.prdata         <= state_next.prdata;
      state_reg.pready         <= state_next.pready;
      state_reg.pslverr        <= state_next.pslverr;
      state_reg.power_off      <= state_next.power_off;
      state_reg.bandgap        <= state_next.bandgap;
      state_reg.use_mux        <= state_next.use_mux;
      state_reg.mux_sel        <= state_next.mux_sel;
      state_reg.capture        <= state_next.capture;
      state_reg.cmp_irq        <= state_next.cmp_irq;
      state_reg.irq            <= state_next.irq;
    end
  end

  // Outputs straight from flops
  assign o_prdata          = state_reg.prdata;
  assign o_pready          = state_reg.pready;
  assign o_pslverr         = state_reg.pslverr;
  assign o_cmp_power_off   = state_reg.power_off;
  assign o_pos_bandgap_sel = state_reg.bandgap;
  assign o_neg_use_mux     = state_reg.use_mux;
  assign o_neg_mux_sel     = state_reg.mux_sel;
  assign o_capture_trigger = state_reg.capture;
  assign o_cmp_irq         = state_reg.cmp_irq;
  assign o_irq             = state_reg.irq;

endmodule // acc_comparator_control

// [verilog/acc_pkg.sv]
// Constants for the comparator control block
package acc_pkg;
  // Register byte addresses on the bus
  localparam logic [11:0] ADDR_SPECIAL_IO  = 12'h000;
  localparam logic [11:0] ADDR_CMP_CTRL    = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h010;
  localparam logic [11:0] ADDR_CORE_CTRL   = 12'h014;
  // Field positions, comparator control register
  localparam int BIT_DISABLE   = 7;
  localparam int BIT_BANDGAP   = 6;
  localparam int BIT_OUT_SYNC  = 5;
  localparam int BIT_IRQ_FLAG  = 4;
  localparam int BIT_IRQ_EN    = 3;
  localparam int BIT_CAPTURE   = 2;
  localparam int BIT_MODE_HI   = 1;
  localparam int BIT_MODE_LO   = 0;
  // Field positions, special function register
  localparam int BIT_NEG_MUX_EN = 3;
  localparam int BIT_SFIO_RO    = 4;
  // Field positions, converter stand-in register
  localparam int BIT_CONV_EN    = 3;
  localparam int SEL_LSB        = 0;
  localparam int SEL_W          = 3;
  // Reset values
  localparam logic [7:0] RST_SPECIAL_IO = 8'h00;
  localparam logic [7:0] RST_CMP_CTRL   = 8'h00;
  localparam logic [3:0] RST_CORE_CTRL  = 4'h0;
  // Edge mode encodings
  localparam logic [1:0] MODE_TOGGLE  = 2'h0;
  localparam logic [1:0] MODE_RSVD    = 2'h1;
  localparam logic [1:0] MODE_FALLING = 2'h2;
  localparam logic [1:0] MODE_RISING  = 2'h3;
  // Interrupt status bit positions
  localparam int EVT_CMP = 0;
  localparam int EVT_W   = 1;
endpackage
